/* rtl/pdp_policy.sv */
// The register offsets and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps
module pdp_policy #(
   parameter int STEP_CYCLES = pdp_pkg::STEP_CYCLES,
   parameter int ADC_CONV_CYCLES = pdp_pkg::ADC_CONV_CYCLES
) (
   input wire logic CLK_I,
   input wire logic RESET_N_I,
   input wire logic HSEL_I,
   input wire logic [31:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic [2:0] HSIZE_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic HREADY_I,
   output logic [31:0] HRDATA_O,
   output logic HREADYOUT_O,
   output logic HRESP_O,
   input wire logic PREDSG_START_I,
   input wire logic DSG_OFF_I,
   input wire logic [15:0] LOAD_SENSE_PIN_MV_I,
   input wire logic [15:0] STACK_MV_I,
   input wire logic [15:0] CURRENT_I,
   input wire logic SAMPLE_VALID_I,
   input pdp_pkg::pdp_cells_type CELL_RAW_MV_I,
   input wire logic SECURITY_LOCK_COMMAND_I,
   input wire logic ENTER_CONFIG_UPDATE_COMMAND_I,
   input wire logic PF_REQUEST_I,
   output pdp_pkg::pdp_cells_type CELL_COMP_MV_O,
   output logic PREDSG_FET_O,
   output logic DSG_FET_O,
   output logic DISCHARGING_O,
   output logic CHARGING_O,
   output logic [4:0] OPEN_WIRE_SINK_O,
   output logic PF_TRIGGER_O,
   output logic RUNTIME_OTP_WRITE_ALLOW_O
);

   // ---------------------------------------------------------------
   // Decode helper
   // ---------------------------------------------------------------
   // Cell slot for an address, 7 when not a resistance register
   function automatic logic [2:0] cell_slot(input logic [7:0] addr);
      logic [7:0] rel;
      rel = addr - pdp_pkg::OFS_CELL1_LINK_RES;
      if (addr >= pdp_pkg::OFS_CELL1_LINK_RES && rel[1:0] == 2'b00 && rel[7:2] < 6'd5)
         cell_slot = rel[4:2];
      else
         cell_slot = 3'd7;
   endfunction

   // ---------------------------------------------------------------
   // Register state
   // ---------------------------------------------------------------
   logic [7:0] duration_reg;
   logic [7:0] delta_reg;
   logic [15:0] dsg_thr_reg;
   logic [15:0] chg_thr_reg;
   logic [7:0] ow_interval_reg;
   pdp_pkg::pdp_cells_type res_reg;
   logic [15:0] init_mfg_reg;
   logic [15:0] mfg_status_reg;
   logic [1:0] fet_test_reg;
   logic wr_pend_reg;
   logic [7:0] wr_addr_reg;
   logic [31:0] rdata_next;
   pdp_pkg::pdp_state_type state_reg;
   pdp_pkg::pdp_state_type state_next;
   logic [7:0] step_cnt_reg;
   logic [4:0] chk_cnt_reg;
   logic [7:0] sec_cnt_reg;
   logic [31:0] conv_cnt_reg;
   logic sink_reg;
   logic sink_next;
   logic [31:0] sink_len_reg;
   pdp_pkg::pdp_status_type status;
   logic tick_step;
   logic tick_sec;

   // ---------------------------------------------------------------
   // Bus slave
   // ---------------------------------------------------------------
   // Zero wait state, always OKAY
   wire logic ahb_take = HSEL_I && HREADY_I && HTRANS_I[1];
   wire logic [7:0] rd_addr = HADDR_I[7:0];
   wire logic [2:0] rd_slot = cell_slot(rd_addr);
   wire logic [2:0] wr_slot = cell_slot(wr_addr_reg);
   wire logic normal_fet = mfg_status_reg[pdp_pkg::BIT_NORMAL_FET_CONTROL_SELECT];
   assign HREADYOUT_O = 1'b1;
   assign HRESP_O = 1'b0;

   // Read multiplexer, unmapped reads zero
   always_comb
   begin
      rdata_next = 32'h0000_0000;
      if (rd_slot != 3'd7)
         rdata_next = {16'h0000, res_reg[rd_slot]};
      else
         case (rd_addr)
            pdp_pkg::OFS_PREDSG_DURATION: rdata_next = {24'h000000, duration_reg};
            pdp_pkg::OFS_PREDSG_DELTA: rdata_next = {24'h000000, delta_reg};
            pdp_pkg::OFS_DSG_THRESHOLD: rdata_next = {16'h0000, dsg_thr_reg};
            pdp_pkg::OFS_CHG_THRESHOLD: rdata_next = {16'h0000, chg_thr_reg};
            pdp_pkg::OFS_OPEN_WIRE_INTERVAL: rdata_next = {24'h000000, ow_interval_reg};
            pdp_pkg::OFS_INIT_MFG_STATUS: rdata_next = {16'h0000, init_mfg_reg};
            pdp_pkg::OFS_MFG_STATUS: rdata_next = {16'h0000, mfg_status_reg};
            pdp_pkg::OFS_POLICY_STATUS: rdata_next = {26'h0000000, status};
            pdp_pkg::OFS_FET_TEST: rdata_next = {30'h00000000, fet_test_reg};
            default: rdata_next = 32'h0000_0000;
         endcase
   end

   // Address phase capture and read data
   always_ff @(posedge CLK_I)
   begin
      if (!RESET_N_I)
      begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         HRDATA_O <= 32'h0000_0000;
      end
      else
      begin
         wr_pend_reg <= ahb_take && HWRITE_I;
         if (ahb_take)
            wr_addr_reg <= HADDR_I[7:0];
         if (ahb_take && !HWRITE_I)
            HRDATA_O <= rdata_next;
      end
   end

   // Settings written in the data phase
   always_ff @(posedge CLK_I)
   begin
      if (!RESET_N_I)
      begin
         duration_reg <= pdp_pkg::RST_PREDSG_DURATION;
         delta_reg <= pdp_pkg::RST_PREDSG_DELTA;
         dsg_thr_reg <= pdp_pkg::RST_DSG_THRESHOLD;
         chg_thr_reg <= pdp_pkg::RST_CHG_THRESHOLD;
         ow_interval_reg <= pdp_pkg::RST_OPEN_WIRE_INTERVAL;
         res_reg <= {pdp_pkg::NUM_CELLS{pdp_pkg::RST_LINK_RES}};
         init_mfg_reg <= pdp_pkg::RST_INIT_MFG_STATUS;
      end
      else if (wr_pend_reg)
      begin
         if (wr_slot != 3'd7)
            res_reg[wr_slot] <= HWDATA_I[15:0];
         case (wr_addr_reg)
            pdp_pkg::OFS_PREDSG_DURATION: duration_reg <= HWDATA_I[7:0];
            pdp_pkg::OFS_PREDSG_DELTA: delta_reg <= HWDATA_I[7:0];
            pdp_pkg::OFS_DSG_THRESHOLD: dsg_thr_reg <= HWDATA_I[15:0];
            pdp_pkg::OFS_CHG_THRESHOLD: chg_thr_reg <= HWDATA_I[15:0];
            pdp_pkg::OFS_OPEN_WIRE_INTERVAL: ow_interval_reg <= HWDATA_I[7:0];
            pdp_pkg::OFS_INIT_MFG_STATUS: init_mfg_reg <= HWDATA_I[15:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge CLK_I)
   begin
      if (!RESET_N_I)
         mfg_status_reg <= pdp_pkg::RST_INIT_MFG_STATUS;
      else if (SECURITY_LOCK_COMMAND_I || ENTER_CONFIG_UPDATE_COMMAND_I)
         mfg_status_reg <= init_mfg_reg;
   end

   // test subcommand only in test mode
   always_ff @(posedge CLK_I)
   begin
      if (!RESET_N_I || normal_fet)
         fet_test_reg <= 2'b00;
      else if (wr_pend_reg && wr_addr_reg == pdp_pkg::OFS_FET_TEST)
         fet_test_reg <= HWDATA_I[1:0];
   end

   // ---------------------------------------------------------------
   // Time bases
   // ---------------------------------------------------------------
   pdp_tick_div #(.DIV(STEP_CYCLES)) u_step_div (
      .clk_i(CLK_I),
      .reset_n_i(RESET_N_I),
      .en_i(1'b1),
      .tick_o(tick_step)
   );

   pdp_tick_div #(.DIV(pdp_pkg::SECOND_STEPS)) u_sec_div (
      .clk_i(CLK_I),
      .reset_n_i(RESET_N_I),
      .en_i(tick_step),
      .tick_o(tick_sec)
   );

   // ---------------------------------------------------------------
   // Predischarge
   // ---------------------------------------------------------------
   wire logic in_predsg = (state_reg == pdp_pkg::ST_PREDSG);
   wire logic [7:0] step_inc = step_cnt_reg + 8'h01;
   wire logic timeout_hit = in_predsg && tick_step && (duration_reg != 8'h00)
      && (step_inc >= duration_reg);
   // check every 250 ms of predischarge
   wire logic check_now = in_predsg && tick_step
      && (chk_cnt_reg == 5'(pdp_pkg::CHECK_STEPS - 1));
   wire logic [17:0] delta_mv = 18'(delta_reg) * 18'(pdp_pkg::DELTA_UNIT_MV);
   // load pin within delta of stack; zero delta skips it
   wire logic volt_hit = check_now && (delta_reg != 8'h00)
      && ((18'(LOAD_SENSE_PIN_MV_I) + delta_mv) >= 18'(STACK_MV_I));

   // DSG_OFF_I wins, entry restarts all
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         pdp_pkg::ST_IDLE: if (PREDSG_START_I) state_next = pdp_pkg::ST_PREDSG;
         // exit by timeout or voltage, a restart wins
         pdp_pkg::ST_PREDSG:
            if ((timeout_hit || volt_hit) && !PREDSG_START_I)
               state_next = pdp_pkg::ST_DSG_ON;
         pdp_pkg::ST_DSG_ON: if (PREDSG_START_I) state_next = pdp_pkg::ST_PREDSG;
         default: state_next = pdp_pkg::ST_IDLE;
      endcase
      if (DSG_OFF_I)
         state_next = pdp_pkg::ST_IDLE;
   end

   // Step and check counters restart on entry
   always_ff @(posedge CLK_I)
   begin
      if (!RESET_N_I)
      begin
         state_reg <= pdp_pkg::ST_IDLE;
         step_cnt_reg <= 8'h00;
         chk_cnt_reg <= 5'h00;
      end
      else
      begin
         state_reg <= state_next;
         if (PREDSG_START_I || !in_predsg)
         begin
            step_cnt_reg <= 8'h00;
            chk_cnt_reg <= 5'h00;
         end
         else if (tick_step)
         begin
            step_cnt_reg <= (step_cnt_reg == 8'hff) ? 8'hff : step_inc;
            chk_cnt_reg <= check_now ? 5'h00 : chk_cnt_reg + 5'h01;
         end
      end
   end

   // ---------------------------------------------------------------
   // Open-wire scheduling
   // ---------------------------------------------------------------
   wire logic ow_start = tick_sec && (ow_interval_reg != 8'h00)
      && (sec_cnt_reg + 8'h01 >= ow_interval_reg);
   // one conversion per interval; zero interval never
   assign sink_next = (ow_interval_reg == 8'h00) ? 1'b0
      : (ow_start ? 1'b1 : (sink_reg && conv_cnt_reg != 32'h0000_0001));

   always_ff @(posedge CLK_I)
   begin
      if (!RESET_N_I)
      begin
         sec_cnt_reg <= 8'h00;
         conv_cnt_reg <= 32'h0000_0000;
         sink_reg <= 1'b0;
         sink_len_reg <= 32'h0000_0000;
      end
      else
      begin
         sink_reg <= sink_next;
         if (ow_interval_reg == 8'h00 || ow_start)
            sec_cnt_reg <= 8'h00;
         else if (tick_sec)
            sec_cnt_reg <= sec_cnt_reg + 8'h01;
         if (ow_start)
            conv_cnt_reg <= 32'(ADC_CONV_CYCLES);
         else if (sink_reg)
            conv_cnt_reg <= conv_cnt_reg - 32'h0000_0001;
         if (sink_next && !sink_reg)
            sink_len_reg <= 32'h0000_0001;
         else if (sink_next)
            sink_len_reg <= sink_len_reg + 32'h0000_0001;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   wire logic [16:0] cur_mag = CURRENT_I[15] ? 17'h00000 - {1'b1, CURRENT_I} : {1'b0, CURRENT_I};
   wire logic pf_allow = mfg_status_reg[pdp_pkg::BIT_FAILURE_CHECK_ALLOW];
   assign status = '{fet_test_mode: !normal_fet, sink_on: sink_reg, charging: CHARGING_O,
      discharging: DISCHARGING_O, dsg_on: state_reg == pdp_pkg::ST_DSG_ON, predsg: in_predsg};

   // Registered classification and drives
   always_ff @(posedge CLK_I)
   begin
      if (!RESET_N_I)
      begin
         DISCHARGING_O <= 1'b0;
         CHARGING_O <= 1'b0;
         PREDSG_FET_O <= 1'b0;
         DSG_FET_O <= 1'b0;
         PF_TRIGGER_O <= 1'b0;
         OPEN_WIRE_SINK_O <= 5'h00;
         RUNTIME_OTP_WRITE_ALLOW_O <= 1'b0;
      end
      else
      begin
         DISCHARGING_O <= CURRENT_I[15] && (cur_mag > 17'(dsg_thr_reg));
         CHARGING_O <= !CURRENT_I[15] && (cur_mag > 17'(chg_thr_reg));
         PREDSG_FET_O <= normal_fet ? (state_next == pdp_pkg::ST_PREDSG)
            : fet_test_reg[pdp_pkg::BIT_TEST_PREDSG_FET];
         DSG_FET_O <= normal_fet ? (state_next == pdp_pkg::ST_DSG_ON)
            : fet_test_reg[pdp_pkg::BIT_TEST_DSG_FET];
         PF_TRIGGER_O <= PF_REQUEST_I && pf_allow;
         OPEN_WIRE_SINK_O <= {5{sink_next}};
         RUNTIME_OTP_WRITE_ALLOW_O <= mfg_status_reg[pdp_pkg::BIT_RUNTIME_OTP_WRITE_ALLOW];
      end
   end

   pdp_cell_comp u_comp (
      .clk_i(CLK_I),
      .reset_n_i(RESET_N_I),
      .sample_valid_i(SAMPLE_VALID_I),
      .current_i(CURRENT_I),
      .raw_mv_i(CELL_RAW_MV_I),
      .res_mohm_i(res_reg),
      .comp_mv_o(CELL_COMP_MV_O)
   );

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RESET_N_I);

   sequence s_no_exit_req;
      !DSG_OFF_I && !PREDSG_START_I;
   endsequence
   property p_timeout_exit;
      timeout_hit && !DSG_OFF_I ##0 s_no_exit_req |=> DSG_FET_O || !normal_fet;
   endproperty
   a_timeout_exit: assert property (p_timeout_exit) else $error("timeout did not end predsg");
   property p_no_limit;
      in_predsg && duration_reg == 8'h00 && !volt_hit ##0 s_no_exit_req |=> in_predsg;
   endproperty
   a_no_limit: assert property (p_no_limit) else $error("predsg left without cause");
   property p_step_bound;
      in_predsg && duration_reg != 8'h00 |-> step_cnt_reg < duration_reg;
   endproperty
   a_step_bound: assert property (p_step_bound) else $error("predsg outlived its limit");
   property p_volt_exit;
      check_now && delta_reg != 8'h00 && LOAD_SENSE_PIN_MV_I >= STACK_MV_I ##0 s_no_exit_req
         |=> state_reg == pdp_pkg::ST_DSG_ON;
   endproperty
   a_volt_exit: assert property (p_volt_exit) else $error("voltage exit missed");
   property p_check_only_on_tick;
      $rose(state_reg == pdp_pkg::ST_DSG_ON) && $past(in_predsg) |-> $past(tick_step);
   endproperty
   a_check_only_on_tick: assert property (p_check_only_on_tick) else $error("exit off tick");
   property p_zero_delta;
      volt_hit |-> delta_reg != 8'h00;
   endproperty
   a_zero_delta: assert property (p_zero_delta) else $error("check ran with zero delta");
   property p_dsg_flag;
      CURRENT_I[15] && cur_mag > 17'(dsg_thr_reg) |=> DISCHARGING_O && !CHARGING_O;
   endproperty
   a_dsg_flag: assert property (p_dsg_flag) else $error("discharge not flagged");
   property p_chg_flag;
      !CURRENT_I[15] && cur_mag > 17'(chg_thr_reg) |=> CHARGING_O && !DISCHARGING_O;
   endproperty
   a_chg_flag: assert property (p_chg_flag) else $error("charge not flagged");
   property p_sink_len;
      $fell(sink_reg) && $past(ow_interval_reg) != 8'h00 |-> sink_len_reg == 32'(ADC_CONV_CYCLES);
   endproperty
   a_sink_len: assert property (p_sink_len) else $error("sink pulse length wrong");
   property p_sink_off;
      ow_interval_reg == 8'h00 |=> OPEN_WIRE_SINK_O == 5'h00;
   endproperty
   a_sink_off: assert property (p_sink_off) else $error("sink on with zero interval");
   property p_mfg_load;
      SECURITY_LOCK_COMMAND_I || ENTER_CONFIG_UPDATE_COMMAND_I |=> mfg_status_reg == $past(init_mfg_reg);
   endproperty
   a_mfg_load: assert property (p_mfg_load) else $error("status not reloaded");
   property p_pf_gate;
      !pf_allow |=> !PF_TRIGGER_O;
   endproperty
   a_pf_gate: assert property (p_pf_gate) else $error("failure raised while disabled");
   property p_test_ignored;
      normal_fet |=> fet_test_reg == 2'b00;
   endproperty
   a_test_ignored: assert property (p_test_ignored) else $error("test command taken");
   property p_restart;
      PREDSG_START_I && !DSG_OFF_I |=> in_predsg && step_cnt_reg == 8'h00 && chk_cnt_reg == 5'h00;
   endproperty
   a_restart: assert property (p_restart) else $error("entry did not restart");
endmodule

/* rtl/pdp_pkg.sv */
package pdp_pkg;

   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_PREDSG_DURATION = 8'h00;
   localparam logic [7:0] OFS_PREDSG_DELTA = 8'h04;
   localparam logic [7:0] OFS_DSG_THRESHOLD = 8'h08;
   localparam logic [7:0] OFS_CHG_THRESHOLD = 8'h0c;
   localparam logic [7:0] OFS_OPEN_WIRE_INTERVAL = 8'h10;
   localparam logic [7:0] OFS_CELL1_LINK_RES = 8'h14;
   localparam logic [7:0] OFS_INIT_MFG_STATUS = 8'h28;
   localparam logic [7:0] OFS_MFG_STATUS = 8'h2c;
   localparam logic [7:0] OFS_POLICY_STATUS = 8'h30;
   localparam logic [7:0] OFS_FET_TEST = 8'h34;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] RST_PREDSG_DURATION = 8'h05;
   localparam logic [7:0] RST_PREDSG_DELTA = 8'h32;
   localparam logic [15:0] RST_DSG_THRESHOLD = 16'h0064;
   localparam logic [15:0] RST_CHG_THRESHOLD = 16'h0032;
   localparam logic [7:0] RST_OPEN_WIRE_INTERVAL = 8'h05;
   localparam logic [15:0] RST_LINK_RES = 16'h0000;
   localparam logic [15:0] RST_INIT_MFG_STATUS = 16'h0040;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int BIT_RUNTIME_OTP_WRITE_ALLOW = 7;
   localparam int BIT_FAILURE_CHECK_ALLOW = 6;
   localparam int BIT_NORMAL_FET_CONTROL_SELECT = 4;
   localparam int BIT_TEST_DSG_FET = 0;
   localparam int BIT_TEST_PREDSG_FET = 1;
   localparam int NUM_CELLS = 5;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_FREQ_HZ = 25_000_000;
   localparam int STEP_TIME_MS = 10;
   localparam int STEP_CYCLES = CLK_FREQ_HZ / 1000 * STEP_TIME_MS;
   localparam int CHECK_PERIOD_MS = 250;
   localparam int CHECK_STEPS = CHECK_PERIOD_MS / STEP_TIME_MS;
   localparam int SECOND_MS = 1000;
   localparam int SECOND_STEPS = SECOND_MS / STEP_TIME_MS;
   localparam int ADC_CONV_US = 3000;
   localparam int ADC_CONV_CYCLES = CLK_FREQ_HZ / 1_000_000 * ADC_CONV_US;
   localparam int DELTA_UNIT_MV = 10;
   localparam int RES_SCALE = 1000;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {ST_IDLE, ST_PREDSG, ST_DSG_ON} pdp_state_type;
   typedef logic [NUM_CELLS-1:0][15:0] pdp_cells_type;
   typedef struct packed {
      logic fet_test_mode;
      logic sink_on;
      logic charging;
      logic discharging;
      logic dsg_on;
      logic predsg;
   } pdp_status_type;

endpackage

/* rtl/pdp_tick_div.sv */
`timescale 1ns/1ps
// Enable divider: one pulse every DIV enabled cycles
module pdp_tick_div #(
   parameter int DIV = 2
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic en_i,
   output logic tick_o
);
   logic [31:0] cnt_reg;
   logic [31:0] cnt_next;
   wire logic wrap = en_i && (cnt_reg == 32'(DIV - 1));

   // Count enabled cycles
   assign cnt_next = wrap ? 32'h0000_0000 : (en_i ? cnt_reg + 32'h0000_0001 : cnt_reg);

   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         cnt_reg <= 32'h0000_0000;
         tick_o <= 1'b0;
      end
      else
      begin
         cnt_reg <= cnt_next;
         tick_o <= wrap;
      end
   end

   property p_tick_single;
      @(posedge clk_i) disable iff (!reset_n_i) tick_o |=> !tick_o || (DIV == 1);
   endproperty
   a_tick_single: assert property (p_tick_single) else $error("divider tick too wide");
endmodule

/* rtl/pdp_cell_comp.sv */
`timescale 1ns/1ps
// Interconnect compensation of five cell voltages
module pdp_cell_comp (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic sample_valid_i,
   input wire logic [15:0] current_i,
   input pdp_pkg::pdp_cells_type raw_mv_i,
   input pdp_pkg::pdp_cells_type res_mohm_i,
   output pdp_pkg::pdp_cells_type comp_mv_o
);
   genvar g;
   generate
      for (g = 0; g < pdp_pkg::NUM_CELLS; g++)
      begin : g_cell
         logic signed [32:0] prod;
         logic signed [33:0] diff;
         logic [15:0] clip;
         assign prod = $signed(current_i) * $signed({1'b0, res_mohm_i[g]});
         assign diff = $signed({18'h00000, raw_mv_i[g]}) - 34'(prod / 33'(pdp_pkg::RES_SCALE));
         assign clip = diff[33] ? 16'h0000 : ((|diff[32:16]) ? 16'hffff : diff[15:0]);

         always_ff @(posedge clk_i)
         begin
            if (!reset_n_i)
               comp_mv_o[g] <= 16'h0000;
            else if (sample_valid_i)
               comp_mv_o[g] <= clip;
         end

         property p_zero_res_pass;
            @(posedge clk_i) disable iff (!reset_n_i)
               sample_valid_i && (res_mohm_i[g] == 16'h0000) |=> comp_mv_o[g] == $past(raw_mv_i[g]);
         endproperty
         a_zero_res_pass: assert property (p_zero_res_pass) else $error("cell passthrough wrong");
      end
   endgenerate
endmodule

/* sim/testbench.sv */
`timescale 1ns/1ps
module testbench;
   logic clk = 0, rst_n = 0, hwrite = 0, start = 0, off = 0, sv = 0, lock = 0, cfg = 0, pf = 0;
   logic [1:0] htrans = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata;
   logic [15:0] ld = 0, stk = 0, cur = 0;
   logic hready, hresp, pfet, dfet, dsg, chg, pft, otp;
   logic [4:0] sink;
   pdp_pkg::pdp_cells_type raw = '0, comp;
   int miscompares = 0, checked = 0, cyc = 0, n;
   // ---------------------------------------------------------------
   // Design and clock
   // ---------------------------------------------------------------
   pdp_policy #(.STEP_CYCLES(20), .ADC_CONV_CYCLES(5)) i_pdp_policy (.CLK_I(clk),
      .RESET_N_I(rst_n), .HSEL_I(1'b1), .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
      .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
      .HREADYOUT_O(hready), .HRESP_O(hresp), .PREDSG_START_I(start), .DSG_OFF_I(off),
      .LOAD_SENSE_PIN_MV_I(ld), .STACK_MV_I(stk), .CURRENT_I(cur), .SAMPLE_VALID_I(sv),
      .CELL_RAW_MV_I(raw), .SECURITY_LOCK_COMMAND_I(lock), .ENTER_CONFIG_UPDATE_COMMAND_I(cfg),
      .PF_REQUEST_I(pf), .CELL_COMP_MV_O(comp), .PREDSG_FET_O(pfet), .DSG_FET_O(dfet),
      .DISCHARGING_O(dsg), .CHARGING_O(chg), .OPEN_WIRE_SINK_O(sink), .PF_TRIGGER_O(pft),
      .RUNTIME_OTP_WRITE_ALLOW_O(otp));
   initial forever #20 clk = ~clk;
   // Hang guard
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 30000)
      begin
         miscompares++;
         tally_and_finish;
      end
   end
   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic bw(input logic [7:0] a, input logic [31:0] d);
      haddr <= {24'h0, a};
      hwrite <= 1'b1;
      htrans <= 2'b10;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      haddr <= {24'h0, a};
      hwrite <= 1'b0;
      htrans <= 2'b10;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'b00;
      do @(posedge clk); while (hready !== 1'b1);
      chk(hrdata, exp);
      chk(hresp, 1'b0);
   endtask
   task automatic wt(input int c, input logic [31:0] exp);
      for (int i = 0; i < c && dfet !== 1'b1; i++) @(posedge clk);
      chk({pfet, dfet}, exp);
   endtask
   task tally_and_finish;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic pulse_start;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
   endtask
   task automatic t_modes;
      rd(8'h00, 32'h5);
      rd(8'h04, 32'h32);
      rd(8'h08, 32'h64);
      rd(8'h0c, 32'h32);
      rd(8'h10, 32'h5);
      rd(8'h2c, 32'h40);
      pf <= 1'b1;
      pulse_start;
      repeat (3) @(posedge clk);
      chk({pfet, dfet, pft}, 32'h1);
      bw(8'h34, 32'h3);
      repeat (2) @(posedge clk);
      chk({pfet, dfet}, 32'h3);
      bw(8'h28, 32'h10);
      cfg <= 1'b1;
      @(posedge clk);
      cfg <= 1'b0;
      off <= 1'b1;
      repeat (3) @(posedge clk);
      off <= 1'b0;
      rd(8'h2c, 32'h10);
      chk(pft, 1'b0);
      bw(8'h34, 32'h3);
      rd(8'h34, 32'h0);
      bw(8'h28, 32'h90);
      lock <= 1'b1;
      @(posedge clk);
      lock <= 1'b0;
      repeat (2) @(posedge clk);
      chk(otp, 1'b1);
      rd(8'h2c, 32'h90);
      $display("test modes done");
   endtask
   task automatic t_predsg;
      bw(8'h00, 32'h1e);
      bw(8'h04, 32'h0);
      ld <= 16'h03e8;
      stk <= 16'h03e8;
      pulse_start;
      repeat (540) @(posedge clk);
      chk({pfet, dfet}, 32'h2);
      wt(80, 32'h1);
      bw(8'h00, 32'h0);
      bw(8'h04, 32'h32);
      ld <= 16'h01f4;
      pulse_start;
      repeat (470) @(posedge clk);
      chk({pfet, dfet}, 32'h2);
      wt(200, 32'h1);
      $display("test predischarge done");
   endtask
   task automatic t_current;
      bw(8'h14, 32'h3e8);
      bw(8'h24, 32'h1f4);
      rd(8'h24, 32'h1f4);
      raw[0] <= 16'h03e8;
      raw[4] <= 16'h03e8;
      cur <= 16'h0064;
      sv <= 1'b1;
      @(posedge clk);
      sv <= 1'b0;
      @(posedge clk);
      chk(comp[0], 32'h384);
      chk(comp[4], 32'h3b6);
      cur <= 16'hff9b;
      repeat (2) @(posedge clk);
      chk({dsg, chg}, 32'h2);
      cur <= 16'hff9c;
      repeat (2) @(posedge clk);
      chk({dsg, chg}, 32'h0);
      cur <= 16'h0033;
      repeat (2) @(posedge clk);
      chk({dsg, chg}, 32'h1);
      cur <= 16'h0032;
      repeat (2) @(posedge clk);
      chk({dsg, chg}, 32'h0);
      $display("test current done");
   endtask
   task automatic t_open_wire;
      bw(8'h10, 32'h0);
      n = 0;
      repeat (4100) @(posedge clk) n += (sink != 0);
      chk(n, 32'h0);
      bw(8'h10, 32'h1);
      for (int i = 0; i < 4100 && sink !== 5'h1f; i++) @(posedge clk);
      n = 0;
      while (sink === 5'h1f && n < 99) @(posedge clk) n++;
      chk(n, 32'h5);
      n = 0;
      while (sink !== 5'h1f && n < 3000) @(posedge clk) n++;
      chk(n, 32'h7cb);
      $display("test open wire done");
   endtask
   task automatic t_reset;
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      chk({pfet, dfet, sink, otp}, 32'h0);
      rd(8'h2c, 32'h40);
      rd(8'h00, 32'h5);
      $display("test reset done");
   endtask
   initial
   begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      t_modes;
      t_predsg;
      t_current;
      t_open_wire;
      t_reset;
      tally_and_finish;
   end
endmodule
